// [src/mesr_pkg.sv]
// package for the motion event status register bank
// assumes an 8-bit register address and 8-bit data from the serial interface
package mesr_pkg;
    // register offsets
    localparam logic [7:0] MESR_KNOCK_SOURCE_OFS   = 8'h38;
    localparam logic [7:0] MESR_ORIENT_SOURCE_OFS  = 8'h39;
    localparam logic [7:0] MESR_STRIDE_CONFIG_OFS  = 8'h3a;
    localparam logic [7:0] MESR_STRIDE_CNT_LO_OFS  = 8'h3b;
    localparam logic [7:0] MESR_STRIDE_CNT_HI_OFS  = 8'h3c;
    localparam logic [7:0] MESR_FUNC_GATE_OFS      = 8'h3d;
    localparam logic [7:0] MESR_FUNC_SOURCE_OFS    = 8'h3e;
    // stride_config fields and reset constants
    localparam int         MESR_CLEAR_BIT          = 7;
    localparam int         MESR_FOUR_G_BIT         = 6;
    localparam logic [5:0] MESR_MIN_THS_RST        = 6'h10;
    localparam logic [7:0] MESR_STRIDE_CONFIG_RST  = 8'h10;
    localparam logic [15:0] MESR_COUNT_RST         = 16'h0000;
    localparam logic [7:0] MESR_ZERO_BYTE          = 8'h00;
endpackage : mesr_pkg

// [src/mesr_regs.sv]
// motion event status register bank: status seen by host software
// assumes engine status inputs are synchronous to sys_clk
//
// Notes on behaviour
// - knock source at 38h, bit7 zero
// - any-knock flag follows either knock kind
// - single and double knock separate flags
// - knock polarity: 0 positive, 1 negative
// - one knock flag per axis
// - orientation source at 39h, bit7 zero
// - position-change flag on orientation change
// - six directional over-threshold flags
// - count-clear bit resets stride count
// - four-g stride mode enable, default off
// - six-bit minimum threshold, default 10h
// - 16-bit stride count, low 3Bh high 3Ch
// - function gate status layout at 3Dh
// - lean flag on tilt event
// - significant-motion flag on event
// - significant-motion init pending bit
// - stride init pending bit
// - stride-detected flag
// - function clock gate state readable
// - function source at 3Eh, upper bits zero
// - lean init pending bit
// - magnitude-module new data flag
`timescale 1ns/1ns
`default_nettype none
module mesr_regs
    import mesr_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        rstn,
    // register access from the serial interface
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    output logic      [7:0]  reg_rdata,
    // knock engine
    input  wire logic        single_knock,
    input  wire logic        double_knock,
    input  wire logic        knock_negative,
    input  wire logic        x_knock,
    input  wire logic        y_knock,
    input  wire logic        z_knock,
    // orientation engine
    input  wire logic        position_change,
    input  wire logic [5:0]  direction_over,
    // stride engine
    input  wire logic        stride_step,
    input  wire logic        stride_detected,
    input  wire logic        stride_init,
    input  wire logic        sigmot_detected,
    input  wire logic        sigmot_init,
    input  wire logic        lean_detected,
    input  wire logic        lean_init,
    input  wire logic [1:0]  scale_select,
    input  wire logic        func_clock_on,
    input  wire logic        module_new_data,
    input  wire logic        hub_done,
    // configuration towards the engines
    output logic             stride_four_g_mode,
    output logic      [5:0]  stride_min_threshold
);

    logic [7:0]  stride_config_r;
    logic [15:0] stride_count_r;
    logic [15:0] stride_count_nxt;
    logic [7:0]  knock_source_r;
    logic [7:0]  orientation_source_r;
    logic [7:0]  function_gate_status_r;
    logic [7:0]  function_source_r;
    logic [7:0]  rdata_nxt;

    // decode; only stride_config accepts writes
    wire cfg_wr = reg_wr && (reg_addr == MESR_STRIDE_CONFIG_OFS);
    wire stride_count_clear = cfg_wr && reg_wdata[MESR_CLEAR_BIT];

    // clear wins over a step in the same cycle: host asked for zero
    assign stride_count_nxt = stride_count_clear ? MESR_COUNT_RST :
        (stride_step ? 16'(stride_count_r + 16'h0001) : stride_count_r);

    wire any_knock_flag = single_knock | double_knock;

    // engine status snapshots into the source registers
    wire [7:0] knock_nxt = {1'b0, any_knock_flag, single_knock,
        double_knock, knock_negative, x_knock, y_knock, z_knock};
    wire [7:0] orient_nxt = {1'b0, position_change, direction_over};
    wire [7:0] gate_nxt = {lean_detected, scale_select, sigmot_detected,
        sigmot_init, stride_init, stride_detected, func_clock_on};
    wire [7:0] fsrc_nxt = {5'b0_0000, lean_init, module_new_data,
        hub_done};

    // read mux; unmapped addresses return zero
    always_comb begin
        case (reg_addr)
            MESR_KNOCK_SOURCE_OFS:  rdata_nxt = knock_source_r;
            MESR_ORIENT_SOURCE_OFS: rdata_nxt = orientation_source_r;
            MESR_STRIDE_CONFIG_OFS: rdata_nxt = stride_config_r;
            MESR_STRIDE_CNT_LO_OFS: rdata_nxt = stride_count_r[7:0];
            MESR_STRIDE_CNT_HI_OFS: rdata_nxt = stride_count_r[15:8];
            MESR_FUNC_GATE_OFS:     rdata_nxt = function_gate_status_r;
            MESR_FUNC_SOURCE_OFS:   rdata_nxt = function_source_r;
            default:                rdata_nxt = MESR_ZERO_BYTE;
        endcase
    end

    // status registers follow the engines every cycle
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            knock_source_r         <= MESR_ZERO_BYTE;
            orientation_source_r   <= MESR_ZERO_BYTE;
            function_gate_status_r <= MESR_ZERO_BYTE;
            function_source_r      <= MESR_ZERO_BYTE;
        end else begin
            knock_source_r         <= knock_nxt;
            orientation_source_r   <= orient_nxt;
            function_gate_status_r <= gate_nxt;
            function_source_r      <= fsrc_nxt;
        end
    end

    // configuration and count; clear bit is a strobe, never stored
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            stride_config_r <= MESR_STRIDE_CONFIG_RST;
            stride_count_r  <= MESR_COUNT_RST;
        end else begin
            if (cfg_wr) begin
                stride_config_r <= {1'b0, reg_wdata[6:0]};
            end
            stride_count_r <= stride_count_nxt;
        end
    end

    // registered outputs
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            reg_rdata            <= MESR_ZERO_BYTE;
            stride_four_g_mode   <= 1'b0;
            stride_min_threshold <= MESR_MIN_THS_RST;
        end else begin
            if (reg_rd) begin
                reg_rdata <= rdata_nxt;
            end
            stride_four_g_mode   <= stride_config_r[MESR_FOUR_G_BIT];
            stride_min_threshold <= stride_config_r[5:0];
        end
    end

endmodule : mesr_regs
`default_nettype wire

// [tb/mesr_checker.sv]
// checker for the motion event status register bank
// assumes a bind onto mesr_regs, ports only
`timescale 1ns/1ns
`default_nettype none
module mesr_checker
    import mesr_pkg::*;
(
    input wire logic       sys_clk,
    input wire logic       rstn,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic       stride_four_g_mode,
    input wire logic [5:0] stride_min_threshold
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    // decoded strobes shared by the properties
    wire cfg_wr = reg_wr && reg_addr == MESR_STRIDE_CONFIG_OFS;
    wire rd_cfg = reg_rd && reg_addr == MESR_STRIDE_CONFIG_OFS;
    wire rd_kn = reg_rd && reg_addr == MESR_KNOCK_SOURCE_OFS;
    wire rd_src = reg_rd && reg_addr == MESR_FUNC_SOURCE_OFS;
    wire rd_off = reg_rd && (reg_addr < 8'h38 || reg_addr > 8'h3e);
    chk_four_g_mode: assert property (cfg_wr |-> ##2
        stride_four_g_mode == $past(reg_wdata[6], 2)) else $error("four g");
    chk_min_ths: assert property (cfg_wr |-> ##2
        stride_min_threshold == $past(reg_wdata[5:0], 2)) else $error("ths");
    chk_ths_reset: assert property ($rose(rstn) |->
        stride_min_threshold == MESR_MIN_THS_RST) else $error("ths reset");
    chk_off_zero: assert property (rd_off |=> reg_rdata == 8'h00)
        else $error("unmapped read");
    chk_knock_top: assert property (rd_kn |=> !reg_rdata[7])
        else $error("knock bit7");
    chk_knock_any: assert property (rd_kn |=>
        reg_rdata[6] == (reg_rdata[5] | reg_rdata[4])) else $error("any");
    chk_src_upper: assert property (rd_src |=> reg_rdata[7:3] == 5'h00)
        else $error("src upper");
    chk_clear_rb: assert property (rd_cfg |=> !reg_rdata[7])
        else $error("clear bit");
    cover property (cfg_wr);
    cover property (rd_kn);
    cover property (rd_off);
endmodule : mesr_checker
bind mesr_regs mesr_checker u_chk (.sys_clk, .rstn, .reg_wr, .reg_rd,
    .reg_addr, .reg_wdata, .reg_rdata, .stride_four_g_mode,
    .stride_min_threshold);
`default_nettype wire

// [tb/mesr_host.sv]
// host model: strobed register reads and writes
// assumes tasks are entered just after a rising edge
`timescale 1ns/1ns
`default_nettype none
module mesr_host (
    input  wire logic       sys_clk,
    output var  logic       reg_wr,
    output var  logic       reg_rd,
    output var  logic [7:0] reg_addr,
    output var  logic [7:0] reg_wdata
);
    logic [7:0] exp_q[$];
    initial {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    // quiet cycle after each strobe so strobes never merge
    task automatic acc(input logic w, input logic [7:0] a, d);
        reg_wr <= w;
        reg_rd <= !w;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        {reg_wr, reg_rd} <= 2'b00;
        @(posedge sys_clk);
    endtask : acc
    task automatic rd(input logic [7:0] a, x);
        exp_q.push_back(x);
        acc(1'b0, a, ~x);
    endtask : rd
endmodule : mesr_host
`default_nettype wire

// [tb/test_mesr_regs.sv]
// bench for the motion event status register bank
// assumes host model drives strobes, bench drives engines
`timescale 1ns/1ns
`default_nettype none
module test_mesr_regs;
    import mesr_pkg::*;
    logic sys_clk, rstn = 0, step = 0, rd_d = 0;
    logic [23:0] e = '0;
    logic [15:0] cnt = '0;
    logic [7:0] reg_rdata, reg_addr, reg_wdata;
    logic reg_wr, reg_rd;
    int miscompares = 0, samples_checked = 0, cyc = 0, n;
    mesr_host host (.sys_clk, .reg_wr, .reg_rd, .reg_addr, .reg_wdata);
    mesr_regs dut (.sys_clk, .rstn, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
        .reg_rdata, .single_knock(e[23]), .double_knock(e[22]),
        .knock_negative(e[21]), .x_knock(e[20]), .y_knock(e[19]),
        .z_knock(e[18]), .position_change(e[17]), .direction_over(e[16:11]),
        .lean_detected(e[10]), .scale_select(e[9:8]), .sigmot_detected(e[7]),
        .sigmot_init(e[6]), .stride_init(e[5]), .stride_detected(e[4]),
        .func_clock_on(e[3]), .lean_init(e[2]), .module_new_data(e[1]),
        .hub_done(e[0]), .stride_step(step), .stride_four_g_mode(),
        .stride_min_threshold());
    initial begin
        sys_clk = 0;
        forever #10 sys_clk = ~sys_clk;
    end
    // one compare point, so every read miss is counted and reported alike
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH %0t read %h want %h", $time, seen, exp);
        end
    endtask : check
    task automatic close_out;
        $display("checked %0d, mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : close_out
    // answers land one cycle after the read strobe
    always @(posedge sys_clk) begin
        if (rd_d && host.exp_q.size() > 0) begin
            check(reg_rdata, host.exp_q.pop_front());
        end else if (rd_d) begin
            check(reg_rdata, ~reg_rdata);
        end
        rd_d <= reg_rd;
        if (++cyc == 3000) begin
            miscompares++;
            close_out();
        end
    end
    initial begin
        void'($urandom(8133));
        repeat (3) @(posedge sys_clk);
        rstn <= 1'b1;
        @(posedge sys_clk);
        host.rd(8'h3a, MESR_STRIDE_CONFIG_RST);
        host.rd(8'h40, MESR_ZERO_BYTE);
        for (int i = 0; i < 6; i++) begin
            e <= 24'($urandom);
            n = $urandom_range(4, 1);
            step <= 1'b1;
            repeat (n) @(posedge sys_clk);
            step <= 1'b0;
            cnt += 16'(n);
            repeat (2) @(posedge sys_clk);
            host.rd(8'h38, {1'b0, e[23] | e[22], e[23:18]});
            host.rd(8'h39, {1'b0, e[17:11]});
            host.rd(8'h3d, e[10:3]);
            host.rd(8'h3e, {5'h00, e[2:0]});
            host.acc(1'b1, 8'h3b, 8'hff);
            host.rd(8'h3b, cnt[7:0]);
            host.rd(8'h3c, cnt[15:8]);
            if (i[0]) begin
                host.acc(1'b1, 8'h3a, {1'b1, e[6:0]});
                cnt = '0;
                host.rd(8'h3a, {1'b0, e[6:0]});
            end
            $display("round %0d done", i);
        end
        close_out();
    end
endmodule : test_mesr_regs
`default_nettype wire
